/* alcs_pkg.sv */
// Purpose: shared constants for the async line config and status block
// Assumes: word bit 0 is the msb, so printed bit n sits at index 15-n
// Notes:   instruction function codes are local to this block
package alcs_pkg;
  localparam int unsigned LINES      = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned CHAR_W     = 8;
  localparam int unsigned LINE_W     = 3;
  localparam int unsigned ERR_W      = 3;
  localparam int unsigned RXE_W      = LINE_W + CHAR_W + ERR_W;
  localparam int unsigned MODEM_W    = 4;
  localparam int unsigned BUF_DEPTH  = 2;
  // line characteristics word fields
  localparam logic [1:0]  FMT_CLASS  = 2'b10;
  localparam int unsigned CLS_HI     = 15;
  localparam int unsigned CLS_LO     = 14;
  localparam int unsigned RATE_HI    = 10;
  localparam int unsigned RATE_LO    = 7;
  localparam int unsigned STOP_HI    = 6;
  localparam int unsigned STOP_LO    = 5;
  localparam int unsigned LEN_HI     = 4;
  localparam int unsigned LEN_LO     = 3;
  localparam int unsigned PAR_HI     = 2;
  localparam int unsigned PAR_LO     = 1;
  localparam int unsigned LOOP_BIT   = 0;
  // select, service and status word fields
  localparam int unsigned SEL_LN_HI  = 3;
  localparam int unsigned SEL_LN_LO  = 1;
  localparam int unsigned SECT_BIT   = 0;
  localparam int unsigned SRV_LN_HI  = 4;
  localparam int unsigned SRV_LN_LO  = 1;
  localparam int unsigned RCLK_BIT   = 8;
  localparam int unsigned FRM_BIT    = 3;
  localparam int unsigned PARE_BIT   = 2;
  localparam int unsigned OVR_BIT    = 1;
  localparam int unsigned MDM_HI     = 4;
  localparam int unsigned MDM_LO     = 1;
  localparam logic [WORD_W-1:0] FMT_RESET = 16'h8000;
  // rate codes
  localparam logic [3:0] RATE_19200 = 4'h1;
  localparam logic [3:0] RATE_75    = 4'h3;
  localparam logic [3:0] RATE_2400A = 4'h7;
  localparam logic [3:0] RATE_9600  = 4'h8;
  localparam logic [3:0] RATE_4800  = 4'h9;
  localparam logic [3:0] RATE_1200  = 4'hB;
  localparam logic [3:0] RATE_2400B = 4'hC;
  localparam logic [3:0] RATE_300   = 4'hD;
  localparam logic [3:0] RATE_110   = 4'hF;
  localparam logic [1:0] STOP_TWO   = 2'b01;
  localparam logic [1:0] LEN_FIVE   = 2'b00;
  localparam logic [1:0] PAR_ODD    = 2'b01;
  localparam logic [1:0] PAR_EVEN   = 2'b10;
  // stop length in half bits
  localparam logic [2:0] HALF_ONE   = 3'h2;
  localparam logic [2:0] HALF_ONEH  = 3'h3;
  localparam logic [2:0] HALF_TWO   = 3'h4;
  localparam logic [3:0] BITS_BASE  = 4'h5;
  typedef enum logic [2:0] {
    ALCS_NOP, ALCS_OUT_SELECT, ALCS_OUT_CONTROL,
    ALCS_IN_SERVICE, ALCS_IN_CHAR, ALCS_IN_STATUS
  } alcs_func_t;
endpackage

/* alcs_buf_if.sv */
`timescale 1ns/1ps
// Purpose: carries the receive stream into and out of the two-entry buffer
// Assumes: one clock, shared clock enable
// Notes:   src side is the main module, store side the buffer
interface alcs_buf_if;
  logic                          ce;
  logic                          push_valid;
  logic                          push_ready;
  logic [alcs_pkg::RXE_W-1:0]    push_data;
  logic                          pop_valid;
  logic                          pop_ready;
  logic [alcs_pkg::RXE_W-1:0]    pop_data;
  modport src   (output ce, push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
  modport store (input ce, push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

/* alcs_rx_buf.sv */
`timescale 1ns/1ps
// Purpose: two-entry buffer for received characters with their line and errors
// Assumes: pop and push may occur in the same cycle
// Notes:   full blocks the source through push_ready
module alcs_rx_buf (
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  alcs_buf_if.store bif
);
  logic [alcs_pkg::RXE_W-1:0] mem [alcs_pkg::BUF_DEPTH];
  logic                       wr_ptr;
  logic                       rd_ptr;
  logic [1:0]                 count;
  wire                        do_push = bif.ce && bif.push_valid && bif.push_ready;
  wire                        do_pop  = bif.ce && bif.pop_valid && bif.pop_ready;

  assign bif.push_ready = (count != 2'h2);
  assign bif.pop_valid  = (count != 2'h0);
  assign bif.pop_data   = mem[rd_ptr];

  always_ff @(posedge mclk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= bif.push_data;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ do_push;
      rd_ptr <= rd_ptr ^ do_pop;
      count  <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  buf_no_overflow_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) count <= 2'h2)
    else $error("receive buffer count beyond two");
endmodule // alcs_rx_buf

/* alcs_top.sv */
`timescale 1ns/1ps
// Purpose: line setting, service, receive and status words of an 8-line async mux
// Assumes: one programmed I/O instruction per io_strobe_i pulse, mclk_i at 20 MHz
// Notes:   answers are registered one cycle after the strobe
// How it works
// - rate field decoded to baud value
// - stop code selects one or two
// - length code gives five to eight
// - five bits turn two into one and a half
// - parity none, odd or even
// - bit 15 enables loopback per line
// - service read returns line and section
// - received character right justified
// - receiver status: framing, parity, overrun
// - modem status: cd, cts, dsr, ri
// - offline shows receiver clock zero level
// - explicit select of line and section
module alcs_top (
  input  wire logic                                  mclk_i,
  input  wire logic                                  arst_n_i,
  input  wire logic                                  ce_i,
  input  wire logic                                  io_strobe_i,
  input  wire logic [2:0]                            io_func_i,
  input  wire logic [alcs_pkg::WORD_W-1:0]           io_data_i,
  output logic      [alcs_pkg::WORD_W-1:0]           io_data_o,
  output logic                                       io_ack_o,
  input  wire logic                                  rx_valid_i,
  input  wire logic [alcs_pkg::RXE_W-1:0]            rx_data_i,
  output logic                                       rx_ready_o,
  input  wire logic [alcs_pkg::LINES-1:0]            tx_req_i,
  input  wire logic [alcs_pkg::LINES-1:0]            modem_chg_i,
  input  wire logic [alcs_pkg::LINES*alcs_pkg::MODEM_W-1:0] modem_i,
  input  wire logic                                  offline_i,
  input  wire logic                                  rcv_clk0_i,
  output logic      [alcs_pkg::LINE_W-1:0]           cur_line_o,
  output logic                                       cur_xmit_o,
  output logic      [14:0]                           baud_o,
  output logic      [2:0]                            stop_half_o,
  output logic      [3:0]                            data_bits_o,
  output logic                                       parity_en_o,
  output logic                                       parity_odd_o,
  output logic      [alcs_pkg::LINES-1:0]            loopback_o
);
  localparam int unsigned PW = alcs_pkg::LINES * alcs_pkg::MODEM_W + 1;

  // **************************************************
  // pin synchronisers
  // **************************************************
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic [PW-1:0] pin_s3;
  logic [PW-1:0] pin_q;
  wire  [PW-1:0] pin_raw = {rcv_clk0_i, modem_i};

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else if (ce_i) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // a level is taken only once the last two stages agree
  for (genvar g = 0; g < PW; g++) begin : g_pin
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        pin_q[g] <= 1'b0;
      end else if (ce_i && (pin_s2[g] == pin_s3[g])) begin
        pin_q[g] <= pin_s3[g];
      end
    end
  end

  // **************************************************
  // decode functions
  // **************************************************
  // rate decode
  function automatic logic [14:0] rate_baud(input logic [3:0] code);
    case (code)
      alcs_pkg::RATE_19200: rate_baud = 15'h4B00;
      alcs_pkg::RATE_75:    rate_baud = 15'h004B;
      alcs_pkg::RATE_2400A: rate_baud = 15'h0960;
      alcs_pkg::RATE_9600:  rate_baud = 15'h2580;
      alcs_pkg::RATE_4800:  rate_baud = 15'h12C0;
      alcs_pkg::RATE_1200:  rate_baud = 15'h04B0;
      alcs_pkg::RATE_2400B: rate_baud = 15'h0960;
      alcs_pkg::RATE_300:   rate_baud = 15'h012C;
      alcs_pkg::RATE_110:   rate_baud = 15'h006E;
      default:              rate_baud = 15'h0000;
    endcase
  endfunction

  function automatic logic [2:0] stop_half(input logic [1:0] stop, input logic [1:0] len);
    if (stop != alcs_pkg::STOP_TWO) begin
      stop_half = alcs_pkg::HALF_ONE;
    end else if (len == alcs_pkg::LEN_FIVE) begin
      stop_half = alcs_pkg::HALF_ONEH;
    end else begin
      stop_half = alcs_pkg::HALF_TWO;
    end
  endfunction

  // **************************************************
  // instruction decode
  // **************************************************
  alcs_pkg::alcs_func_t func;
  assign func = alcs_pkg::alcs_func_t'(io_func_i);
  wire take       = ce_i && io_strobe_i;
  wire do_select  = take && (func == alcs_pkg::ALCS_OUT_SELECT);
  wire do_fmt     = take && (func == alcs_pkg::ALCS_OUT_CONTROL) &&
                    (io_data_i[alcs_pkg::CLS_HI:alcs_pkg::CLS_LO] == alcs_pkg::FMT_CLASS);
  wire do_service = take && (func == alcs_pkg::ALCS_IN_SERVICE);
  wire do_char    = take && (func == alcs_pkg::ALCS_IN_CHAR);
  wire do_status  = take && (func == alcs_pkg::ALCS_IN_STATUS);

  // **************************************************
  // receive buffer
  // **************************************************
  alcs_buf_if bif ();
  assign bif.ce         = ce_i;
  assign bif.push_valid = rx_valid_i;
  assign bif.push_data  = rx_data_i;
  assign bif.pop_ready  = do_char;
  assign rx_ready_o     = bif.push_ready;
  alcs_rx_buf u_buf (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .bif      (bif)
  );
  wire [alcs_pkg::LINE_W-1:0] head_line = bif.pop_data[alcs_pkg::RXE_W-1 -: alcs_pkg::LINE_W];
  // an empty buffer reads as zero, never as a stale entry
  wire [alcs_pkg::CHAR_W-1:0] head_char = bif.pop_valid ? bif.pop_data[alcs_pkg::ERR_W +: alcs_pkg::CHAR_W] : '0;
  wire [alcs_pkg::ERR_W-1:0]  head_err  = bif.pop_valid ? bif.pop_data[alcs_pkg::ERR_W-1:0] : '0;

  // **************************************************
  // service arbitration
  // **************************************************
  // receiver first, then modem change, then transmitter, lowest line wins for modem and transmitter
  logic [alcs_pkg::LINE_W-1:0] mdm_line;
  logic [alcs_pkg::LINE_W-1:0] tx_line;
  always_comb begin
    mdm_line = '0;
    tx_line  = '0;
    for (int i = alcs_pkg::LINES - 1; i >= 0; i--) begin
      if (modem_chg_i[i]) begin
        mdm_line = alcs_pkg::LINE_W'(i);
      end
      if (tx_req_i[i]) begin
        tx_line = alcs_pkg::LINE_W'(i);
      end
    end
  end
  wire                         srv_rx    = bif.pop_valid;
  wire                         srv_mdm   = !srv_rx && (modem_chg_i != '0);
  wire                         srv_tx    = !srv_rx && !srv_mdm && (tx_req_i != '0);
  wire [alcs_pkg::LINE_W-1:0]  srv_line  = srv_rx ? head_line : (srv_mdm ? mdm_line : tx_line);

  // **************************************************
  // current line, per-line settings
  // **************************************************
  logic [alcs_pkg::WORD_W-1:0] fmt [alcs_pkg::LINES];
  logic                        status_modem;
  logic                        status_valid;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_line_o   <= '0;
      cur_xmit_o   <= 1'b0;
      status_modem <= 1'b0;
      status_valid <= 1'b0;
    end else if (do_select) begin
      cur_line_o   <= io_data_i[alcs_pkg::SEL_LN_HI:alcs_pkg::SEL_LN_LO];
      cur_xmit_o   <= io_data_i[alcs_pkg::SECT_BIT];
      status_valid <= 1'b0;
    end else if (do_service) begin
      cur_line_o   <= srv_line;
      cur_xmit_o   <= srv_tx;
      status_modem <= srv_mdm;
      status_valid <= !srv_tx;
    end
  end

  for (genvar l = 0; l < alcs_pkg::LINES; l++) begin : g_line
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        fmt[l] <= alcs_pkg::FMT_RESET;
      end else if (do_fmt && (cur_line_o == alcs_pkg::LINE_W'(l))) begin
        fmt[l] <= io_data_i;
      end
    end
    assign loopback_o[l] = fmt[l][alcs_pkg::LOOP_BIT];
  end

  wire [alcs_pkg::WORD_W-1:0] cur_fmt = fmt[cur_line_o];
  wire [1:0] cur_len  = cur_fmt[alcs_pkg::LEN_HI:alcs_pkg::LEN_LO];
  wire [1:0] cur_par  = cur_fmt[alcs_pkg::PAR_HI:alcs_pkg::PAR_LO];

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      baud_o       <= '0;
      stop_half_o  <= alcs_pkg::HALF_ONE;
      data_bits_o  <= alcs_pkg::BITS_BASE;
      parity_en_o  <= 1'b0;
      parity_odd_o <= 1'b0;
    end else if (ce_i) begin
      baud_o       <= rate_baud(cur_fmt[alcs_pkg::RATE_HI:alcs_pkg::RATE_LO]);
      stop_half_o  <= stop_half(cur_fmt[alcs_pkg::STOP_HI:alcs_pkg::STOP_LO], cur_len);
      data_bits_o  <= alcs_pkg::BITS_BASE + {2'b00, cur_len};
      parity_en_o  <= (cur_par == alcs_pkg::PAR_ODD) || (cur_par == alcs_pkg::PAR_EVEN);
      parity_odd_o <= (cur_par == alcs_pkg::PAR_ODD);
    end
  end

  // **************************************************
  // input words
  // **************************************************
  logic [alcs_pkg::WORD_W-1:0] srv_word;
  logic [alcs_pkg::WORD_W-1:0] chr_word;
  logic [alcs_pkg::WORD_W-1:0] sts_word;
  wire  [alcs_pkg::MODEM_W-1:0] cur_mdm = pin_q[cur_line_o*alcs_pkg::MODEM_W +: alcs_pkg::MODEM_W];
  always_comb begin
    srv_word = '0;
    chr_word = '0;
    sts_word = '0;
    srv_word[alcs_pkg::SRV_LN_HI:alcs_pkg::SRV_LN_LO] = {1'b0, srv_line};
    srv_word[alcs_pkg::SECT_BIT] = srv_tx;
    chr_word[alcs_pkg::CHAR_W-1:0] = head_char;
    sts_word[alcs_pkg::RCLK_BIT] = offline_i && pin_q[PW-1];
    if (status_modem) begin
      sts_word[alcs_pkg::MDM_HI:alcs_pkg::MDM_LO] = cur_mdm;
      sts_word[alcs_pkg::SECT_BIT] = 1'b1;
    end else begin
      sts_word[alcs_pkg::FRM_BIT]  = head_err[2];
      sts_word[alcs_pkg::PARE_BIT] = head_err[1];
      sts_word[alcs_pkg::OVR_BIT]  = head_err[0];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_data_o <= '0;
      io_ack_o  <= 1'b0;
    end else if (ce_i) begin
      io_ack_o  <= io_strobe_i;
      if (do_service) begin
        io_data_o <= srv_word;
      end else if (do_char) begin
        io_data_o <= chr_word;
      end else if (do_status) begin
        io_data_o <= sts_word;
      end
    end
  end

  // **************************************************
  // checks
  // **************************************************
  // rate decode
  rate_19200_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && cur_fmt[alcs_pkg::RATE_HI:alcs_pkg::RATE_LO] == alcs_pkg::RATE_19200 |=> baud_o == 15'h4B00)
    else $error("rate code one not decoded as 19200");
  five_bit_stop_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && cur_len == 2'b00 && cur_fmt[alcs_pkg::STOP_HI:alcs_pkg::STOP_LO] == 2'b01 |=> stop_half_o == 3'h3)
    else $error("five bit two stop not one and a half");
  word_len_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && cur_len == 2'b11 |=> data_bits_o == 4'h8)
    else $error("eight bit length wrong");
  fmt_store_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_fmt |=> loopback_o[$past(cur_line_o)] == $past(io_data_i[alcs_pkg::LOOP_BIT]))
    else $error("characteristics word not stored");
  select_line_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_select |=> cur_line_o == $past(io_data_i[3:1]) && cur_xmit_o == $past(io_data_i[0]) && !status_valid)
    else $error("explicit select not taken");
  service_word_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_service && srv_rx |=> io_ack_o && io_data_o[0] == 1'b0 && io_data_o[3:1] == $past(head_line))
    else $error("service word wrong for receiver");
  rx_char_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_char |=> io_data_o[7:0] == $past(head_char) && io_data_o[15:8] == 8'h00)
    else $error("received character misplaced");
  rx_status_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_status && !status_modem |=> io_data_o[0] == 1'b0 && io_data_o[3] == $past(head_err[2]))
    else $error("receiver status wrong");
  modem_status_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_status && status_modem |=> io_data_o[0] && io_data_o[4:1] == $past(cur_mdm))
    else $error("modem status wrong");
  rclk_online_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_status && !offline_i |=> io_data_o[8] == 1'b0)
    else $error("clock bit shown while on line");
endmodule // alcs_top

/* alcs_host_model.sv */
`timescale 1ns/1ps
// Purpose: host side issuing programmed I/O instructions
// Assumes: one instruction in flight, answer one edge after the strobe
// Notes:   data lines show the inverse word once the strobe is released
module alcs_host_model (
  input  wire logic        mclk_i,
  input  wire logic        io_ack_i,
  input  wire logic [15:0] io_data_i,
  output logic             io_strobe_o,
  output logic [2:0]       io_func_o,
  output logic [15:0]      io_data_o
);
  initial begin
    io_strobe_o = 1'b0;
    io_func_o   = 3'h0;
    io_data_o   = 16'h0000;
  end

  // callers pass assigned codes, status only after service read
  task automatic instr(input logic [2:0] fn, input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    @(posedge mclk_i);
    io_strobe_o <= 1'b1;
    io_func_o   <= fn;
    io_data_o   <= wd;
    @(posedge mclk_i);
    io_strobe_o <= 1'b0;
    io_data_o   <= ~wd;
    @(negedge mclk_i);
    ok = io_ack_i;
    rd = io_data_i;
  endtask
endmodule // alcs_host_model

/* tb.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench for the line config and status block
// Assumes: answers sampled on the falling edge after the ack edge
// Notes:   only assigned rate, stop and parity codes are written
module tb;
  localparam logic [2:0] F_SEL = alcs_pkg::ALCS_OUT_SELECT;
  localparam logic [2:0] F_CTL = alcs_pkg::ALCS_OUT_CONTROL;
  localparam logic [2:0] F_SRV = alcs_pkg::ALCS_IN_SERVICE;
  localparam logic [2:0] F_CHR = alcs_pkg::ALCS_IN_CHAR;
  localparam logic [2:0] F_STS = alcs_pkg::ALCS_IN_STATUS;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        strobe, ack, rx_valid = 1'b0, rx_ready, offline = 1'b0, rclk0 = 1'b0;
  logic [2:0]  func, cur_line;
  logic [15:0] wdata, rdata;
  logic [13:0] rx_data = 14'h0000;
  logic [7:0]  tx_req = 8'h00, modem_chg = 8'h00, loopback;
  logic [31:0] modem = 32'h0000_0000;
  logic        cur_xmit, par_en, par_odd;
  logic [14:0] baud;
  logic [2:0]  stop_half;
  logic [3:0]  data_bits;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #25 mclk_i = ~mclk_i;

  alcs_top alcs_top_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .io_strobe_i(strobe),
    .io_func_i(func), .io_data_i(wdata), .io_data_o(rdata), .io_ack_o(ack), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_ready_o(rx_ready), .tx_req_i(tx_req), .modem_chg_i(modem_chg),
    .modem_i(modem), .offline_i(offline), .rcv_clk0_i(rclk0), .cur_line_o(cur_line),
    .cur_xmit_o(cur_xmit), .baud_o(baud), .stop_half_o(stop_half), .data_bits_o(data_bits),
    .parity_en_o(par_en), .parity_odd_o(par_odd), .loopback_o(loopback));

  alcs_host_model alcs_host_model_inst (.mclk_i(mclk_i), .io_ack_i(ack), .io_data_i(rdata),
    .io_strobe_o(strobe), .io_func_o(func), .io_data_o(wdata));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test;
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic op(input logic [2:0] fn, input logic [15:0] wd, output logic [15:0] rd);
    logic ok;
    alcs_host_model_inst.instr(fn, wd, rd, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
  endtask

  // decoded outputs land one edge after the ack
  task automatic setfmt(input logic [15:0] wd);
    logic [15:0] rd;
    op(F_CTL, wd, rd);
    @(negedge mclk_i);
  endtask

  function automatic logic [15:0] fmt(logic [3:0] r, logic [1:0] s, logic [1:0] l, logic [1:0] p, logic lb);
    return {2'b10, 3'b000, r, s, l, p, lb};
  endfunction

  task automatic push(input logic [13:0] d);
    @(posedge mclk_i);
    rx_valid <= 1'b1;
    rx_data  <= d;
    @(posedge mclk_i);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rate;
    logic [3:0]  code [9] = '{4'h1, 4'h3, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hF};
    logic [14:0] rate [9] = '{15'h4B00, 15'h004B, 15'h0960, 15'h2580, 15'h12C0, 15'h04B0, 15'h0960,
                              15'h012C, 15'h006E};
    for (int i = 0; i < 9; i++) begin
      setfmt(fmt(code[i], 2'b00, 2'b11, 2'b00, 1'b0));
      chk("baud", {1'b0, rate[i]}, {1'b0, baud});
    end
  endtask

  task automatic t_frame;
    logic [1:0] p;
    logic [2:0] st;
    for (int l = 0; l < 4; l++) begin
      for (int s = 0; s < 2; s++) begin
        p = 2'(l % 3);
        st = (s == 0) ? 3'h2 : ((l == 0) ? 3'h3 : 3'h4);
        setfmt(fmt(4'h8, s[1:0], l[1:0], p, 1'b0));
        chk("frame", {7'h00, st, 4'(5 + l), p != 2'b00, p == 2'b01},
            {7'h00, stop_half, data_bits, par_en, par_odd});
      end
    end
  endtask

  task automatic t_loop;
    logic [15:0] rd;
    op(F_SEL, 16'h000B, rd);
    chk("select", 16'h000B, {12'h000, cur_line, cur_xmit});
    setfmt(fmt(4'h8, 2'b00, 2'b11, 2'b00, 1'b1));
    chk("loop on", 16'h0020, {8'h00, loopback});
    setfmt(16'h4000);
    chk("class", 16'h0020, {8'h00, loopback});
    setfmt(fmt(4'h8, 2'b00, 2'b11, 2'b00, 1'b0));
    chk("loop off", 16'h0000, {8'h00, loopback});
  endtask

  task automatic t_rx;
    logic [15:0] rd;
    push({3'h3, 8'hA5, 3'b101});
    push({3'h6, 8'h3C, 3'b010});
    @(negedge mclk_i);
    chk("full", 16'h0000, {15'h0000, rx_ready});
    op(F_SRV, 16'h0000, rd);
    chk("srv rx", 16'h0006, rd);
    op(F_STS, 16'h0000, rd);
    chk("sts rx", 16'h000A, {7'h00, rd[8:0]});
    op(F_CHR, 16'h0000, rd);
    chk("char", 16'h00A5, {8'h00, rd[7:0]});
    chk("drain", 16'h0001, {15'h0000, rx_ready});
    op(F_SRV, 16'h0000, rd);
    chk("srv rx2", 16'h000C, rd);
    op(F_STS, 16'h0000, rd);
    chk("sts rx2", 16'h0004, {7'h00, rd[8:0]});
    op(F_CHR, 16'h0000, rd);
    chk("char2", 16'h003C, {8'h00, rd[7:0]});
    op(F_CHR, 16'h0000, rd);
    chk("empty", 16'h0000, {8'h00, rd[7:0]});
    op(F_SRV, 16'h0000, rd);
    chk("srv none", 16'h0000, rd);
  endtask

  task automatic t_modem;
    logic [15:0] rd;
    @(posedge mclk_i);
    modem   <= 32'h0000_0A00;
    offline <= 1'b1;
    rclk0   <= 1'b1;
    repeat (10) @(posedge mclk_i);
    modem_chg <= 8'h04;
    op(F_SRV, 16'h0000, rd);
    chk("srv modem", 16'h0004, rd);
    op(F_STS, 16'h0000, rd);
    chk("sts modem", 16'h0115, {7'h00, rd[8:0]});
    @(posedge mclk_i);
    modem_chg <= 8'h00;
    tx_req    <= 8'h10;
    op(F_SRV, 16'h0000, rd);
    chk("srv tx", 16'h0009, rd);
    chk("cur tx", 16'h0009, {12'h000, cur_line, cur_xmit});
  endtask

  // clock enable low must swallow a strobe and leave the selection alone
  task automatic t_freeze;
    logic [15:0] rd;
    logic        ok;
    @(posedge mclk_i);
    ce_i <= 1'b0;
    alcs_host_model_inst.instr(F_SEL, 16'h0007, rd, ok);
    chk("frozen ack", 16'h0000, {15'h0000, ok});
    chk("frozen sel", 16'h0009, {12'h000, cur_line, cur_xmit});
    @(posedge mclk_i);
    ce_i <= 1'b1;
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(negedge mclk_i);
    @(negedge mclk_i);
    chk("reset fmt", 16'h0250, {1'b0, baud}  | {5'h00, stop_half, data_bits, 4'h0});
    chk("reset misc", 16'h0001, {7'h00, loopback, rx_ready});
    t_rate();
    t_frame();
    t_loop();
    t_rx();
    t_modem();
    t_freeze();
    finish_test();
  end
endmodule // tb
